/* design/return_path_exec.sv */
// Added by the designer: the register offsets and the Wishbone slave port.
`timescale 1ns/1ns
`default_nettype none
module return_path_exec #(
    parameter int PC_W = ret_pkg::PC_WIDTH
) (
    input wire logic CLK_IN,
    input wire logic SYS_RST_IN,
    input wire logic WB_CYC_IN,
    input wire logic WB_STB_IN,
    input wire logic WB_WE_IN,
    input wire logic [ret_pkg::ADR_W-1:0] WB_ADR_IN,
    input wire logic [3:0] WB_SEL_IN,
    input wire logic [31:0] WB_DAT_IN,
    output logic [31:0] WB_DAT_OUT,
    output logic WB_ACK_OUT,
    input wire logic EXEC_VALID_IN,
    input wire ret_pkg::ret_instr_t EXEC_IN,
    input wire logic [PC_W-1:0] STACK_TOP_IN,
    output logic EXEC_READY_OUT,
    output logic STACK_POP_OUT,
    output logic PC_LOAD_OUT,
    output logic [PC_W-1:0] PC_OUT,
    output logic FETCH_NOP_OUT
);
    import ret_pkg::*;

    // the register map only has room for a 32-bit program counter
    generate
        if (PC_W < 1 || PC_W > 32) begin : g_bad_pc
            $error("PC_W must be between 1 and 32");
        end
    endgenerate

    // byte-lane merge, shared by accumulator, flags, bank select and the latch register
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                               input logic [3:0] sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction : lane_merge

    ret_state_t state_ff, nxt_state;
    logic [DATA_W-1:0] acc_ff, flags_ff, bank_ff, acc_sh_ff, flags_sh_ff, bank_sh_ff;
    logic [DATA_W-1:0] nxt_acc, nxt_flags, nxt_bank, nxt_acc_sh, nxt_flags_sh, nxt_bank_sh;
    logic [2:0] irq_ff, nxt_irq;
    logic [12:0] latch_ff, nxt_latch;
    logic [PC_W-1:0] pc_ff;
    logic pop_ff, nop_ff, ack_ff;
    logic [31:0] rd_ff, rd_mux;

    // bus decode; a write lands at the edge where the master sees ack
    wire bus_req = WB_CYC_IN & WB_STB_IN;
    wire sw_wr = bus_req & WB_WE_IN & ack_ff;
    wire wr_acc = sw_wr & (WB_ADR_IN == OFF_ACC);
    wire wr_flags = sw_wr & (WB_ADR_IN == OFF_FLAGS);
    wire wr_bank = sw_wr & (WB_ADR_IN == OFF_BANK);
    wire wr_acc_sh = sw_wr & (WB_ADR_IN == OFF_ACC_SH);
    wire wr_flags_sh = sw_wr & (WB_ADR_IN == OFF_FLAGS_SH);
    wire wr_bank_sh = sw_wr & (WB_ADR_IN == OFF_BANK_SH);
    wire wr_irq = sw_wr & (WB_ADR_IN == OFF_IRQ);
    wire wr_latch = sw_wr & (WB_ADR_IN == OFF_LATCH);

    // instruction take and its flavours
    wire idle = (state_ff == ST_IDLE);
    wire take = EXEC_VALID_IN & idle;
    wire is_irq = take & (EXEC_IN.op == OP_IRQ_RETURN);
    wire is_lit = take & (EXEC_IN.op == OP_LITERAL_RETURN);
    wire fast = take & EXEC_IN.fast_sel & (EXEC_IN.op != OP_LITERAL_RETURN);
    wire [DATA_W-1:0] wb_byte = WB_DAT_IN[DATA_W-1:0];

    // merged write words; a call result cannot be part-selected, so cut them here
    wire [31:0] acc_wr_word = lane_merge({24'h0, acc_ff}, WB_DAT_IN, WB_SEL_IN);
    wire [31:0] flags_wr_word = lane_merge({24'h0, flags_ff}, WB_DAT_IN, WB_SEL_IN);
    wire [31:0] bank_wr_word = lane_merge({24'h0, bank_ff}, WB_DAT_IN, WB_SEL_IN);
    wire [31:0] latch_wr_word = lane_merge({19'h0, latch_ff}, WB_DAT_IN, WB_SEL_IN);

    // hardware wins over a software write in the same edge
    assign nxt_acc = is_lit ? EXEC_IN.literal :
                     fast ? acc_sh_ff :
                     wr_acc ? acc_wr_word[DATA_W-1:0] :
                     acc_ff;
    assign nxt_flags = fast ? flags_sh_ff :
                       wr_flags ? flags_wr_word[DATA_W-1:0] :
                       flags_ff;
    assign nxt_bank = fast ? bank_sh_ff :
                      wr_bank ? bank_wr_word[DATA_W-1:0] :
                      bank_ff;
    assign nxt_acc_sh = (wr_acc_sh & WB_SEL_IN[0]) ? wb_byte : acc_sh_ff;
    assign nxt_flags_sh = (wr_flags_sh & WB_SEL_IN[0]) ? wb_byte : flags_sh_ff;
    assign nxt_bank_sh = (wr_bank_sh & WB_SEL_IN[0]) ? wb_byte : bank_sh_ff;

    // without priority mode the high bit is the single global enable;
    // with it, the high level is reopened first, else the low one
    wire [2:0] irq_sw = (wr_irq & WB_SEL_IN[0]) ? WB_DAT_IN[2:0] : irq_ff;
    wire set_low = irq_ff[IRQ_PRIO_BIT] & irq_ff[IRQ_HIGH_BIT];
    assign nxt_irq = !is_irq ? irq_sw :
                     set_low ? (irq_sw | (3'h1 << IRQ_LOW_BIT)) :
                     (irq_sw | (3'h1 << IRQ_HIGH_BIT));

    // latches follow software only, never a return
    assign nxt_latch = wr_latch ? latch_wr_word[12:0] : latch_ff;

    // second cycle of every return is a plain no-operation
    assign nxt_state = take ? ST_NOP : ST_IDLE;

    // read mux; unmapped offsets read as zero
    assign rd_mux = (WB_ADR_IN == OFF_ACC) ? {24'h0, acc_ff} :
                    (WB_ADR_IN == OFF_FLAGS) ? {24'h0, flags_ff} :
                    (WB_ADR_IN == OFF_BANK) ? {24'h0, bank_ff} :
                    (WB_ADR_IN == OFF_ACC_SH) ? {24'h0, acc_sh_ff} :
                    (WB_ADR_IN == OFF_FLAGS_SH) ? {24'h0, flags_sh_ff} :
                    (WB_ADR_IN == OFF_BANK_SH) ? {24'h0, bank_sh_ff} :
                    (WB_ADR_IN == OFF_IRQ) ? {29'h0, irq_ff} :
                    (WB_ADR_IN == OFF_PC) ? 32'(pc_ff) :
                    (WB_ADR_IN == OFF_LATCH) ? {19'h0, latch_ff} :
                    (WB_ADR_IN == OFF_STATUS) ? {30'h0, nop_ff, idle} :
                    RST_WORD;

    // architectural registers
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            acc_ff <= RST_BYTE;
            flags_ff <= RST_BYTE;
            bank_ff <= RST_BYTE;
            acc_sh_ff <= RST_BYTE;
            flags_sh_ff <= RST_BYTE;
            bank_sh_ff <= RST_BYTE;
            irq_ff <= RST_IRQ;
            latch_ff <= RST_WORD[12:0];
        end else begin
            acc_ff <= nxt_acc;
            flags_ff <= nxt_flags;
            bank_ff <= nxt_bank;
            acc_sh_ff <= nxt_acc_sh;
            flags_sh_ff <= nxt_flags_sh;
            bank_sh_ff <= nxt_bank_sh;
            irq_ff <= nxt_irq;
            latch_ff <= nxt_latch;
        end
    end

    // sequencing: pop and PC load are one-cycle pulses in the nop cycle
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            state_ff <= ST_IDLE;
            pc_ff <= '0;
            pop_ff <= 1'b0;
            nop_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            pop_ff <= take;
            nop_ff <= take;
            if (take) begin
                pc_ff <= STACK_TOP_IN;
            end
        end
    end

    // bus slave: ack one cycle after the request, then drop for a cycle
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            ack_ff <= 1'b0;
            rd_ff <= RST_WORD;
        end else begin
            ack_ff <= bus_req & ~ack_ff;
            if (bus_req & ~ack_ff) begin
                rd_ff <= rd_mux;
            end
        end
    end

    assign WB_ACK_OUT = ack_ff;
    assign WB_DAT_OUT = rd_ff;
    assign EXEC_READY_OUT = idle;
    assign STACK_POP_OUT = pop_ff;
    assign PC_LOAD_OUT = pop_ff;
    assign PC_OUT = pc_ff;
    assign FETCH_NOP_OUT = nop_ff;

    // checks on the return sequence
    sequence s_taken;
        EXEC_VALID_IN && EXEC_READY_OUT;
    endsequence

    sequence s_two_cycle;
        FETCH_NOP_OUT && !EXEC_READY_OUT ##1 EXEC_READY_OUT && !FETCH_NOP_OUT;
    endsequence

    pc_from_stack_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
        s_taken |=> STACK_POP_OUT && PC_OUT == $past(STACK_TOP_IN))
        else $error("pc not loaded from popped stack top");

    irq_reenable_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
        s_taken and (EXEC_IN.op == OP_IRQ_RETURN && !wr_irq)
        |=> irq_ff[IRQ_HIGH_BIT] || irq_ff[IRQ_LOW_BIT])
        else $error("interrupt return left enables clear");

    fast_restore_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
        s_taken and (EXEC_IN.fast_sel && EXEC_IN.op != OP_LITERAL_RETURN)
        |=> acc_ff == $past(acc_sh_ff) && flags_ff == $past(flags_sh_ff)
            && bank_ff == $past(bank_sh_ff))
        else $error("shadow restore missed");

    live_hold_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
        s_taken and (!EXEC_IN.fast_sel && EXEC_IN.op != OP_LITERAL_RETURN
        && !wr_acc && !wr_flags && !wr_bank)
        |=> $stable(acc_ff) && $stable(flags_ff) && $stable(bank_ff))
        else $error("plain return changed live registers");

    latch_keep_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
        (s_taken and !wr_latch) |=> $stable(latch_ff))
        else $error("return touched pc latches");

    literal_load_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
        s_taken and (EXEC_IN.op == OP_LITERAL_RETURN)
        |=> acc_ff == $past(EXEC_IN.literal) && PC_OUT == $past(STACK_TOP_IN))
        else $error("literal return wrong");

    two_cycle_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
        s_taken |=> s_two_cycle)
        else $error("return not two cycles");
endmodule : return_path_exec
`default_nettype wire

/* shared/ret_pkg.sv */
// Functional notes
// - interrupt return pops the return stack and loads its top into the PC
// - interrupt return sets the high or low priority global interrupt enable
// - fast select 1 restores accumulator, flags, bank select from their shadows, except on literal return
// - fast select 0 leaves accumulator, flags and bank select untouched, except that literal return loads the accumulator
// - returns never modify the upper and high PC latch registers
// - literal return loads the accumulator with literal, PC from popped top
`default_nettype none
package ret_pkg;
    localparam int PC_WIDTH = 21;
    localparam int DATA_W = 8;
    localparam int ADR_W = 8;
    // word-aligned byte offsets of the register file
    localparam logic [7:0] OFF_ACC = 8'h00;
    localparam logic [7:0] OFF_FLAGS = 8'h04;
    localparam logic [7:0] OFF_BANK = 8'h08;
    localparam logic [7:0] OFF_ACC_SH = 8'h0C;
    localparam logic [7:0] OFF_FLAGS_SH = 8'h10;
    localparam logic [7:0] OFF_BANK_SH = 8'h14;
    localparam logic [7:0] OFF_IRQ = 8'h18;
    localparam logic [7:0] OFF_PC = 8'h1C;
    localparam logic [7:0] OFF_LATCH = 8'h20;
    localparam logic [7:0] OFF_STATUS = 8'h24;
    // interrupt control field positions
    localparam int IRQ_HIGH_BIT = 0;
    localparam int IRQ_LOW_BIT = 1;
    localparam int IRQ_PRIO_BIT = 2;
    // latch register field positions: high latch [7:0], upper latch [12:8]
    localparam int LATCH_HIGH_LSB = 0;
    localparam int LATCH_UPPER_LSB = 8;
    localparam int LATCH_UPPER_W = 5;
    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [2:0] RST_IRQ = 3'h0;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    typedef enum logic [1:0] {
        OP_IRQ_RETURN = 2'h0,  // irq_return_op
        OP_SUB_RETURN = 2'h1,
        OP_LITERAL_RETURN = 2'h2  // literal_return_op
    } ret_op_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h1,
        ST_NOP = 2'h2
    } ret_state_t;

    // one return instruction as handed over by the decoder
    typedef struct packed {
        ret_op_t op;
        logic fast_sel;
        logic [DATA_W-1:0] literal;
    } ret_instr_t;
endpackage : ret_pkg
`default_nettype wire

/* dv/return_path_exec_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module return_path_exec_tb_top;
    import ret_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [ADR_W-1:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] dat_out, rdat;
    logic ack, ready, pop, load, nop;
    logic xvalid = 1'b0;
    ret_instr_t xin = '0;
    logic [PC_WIDTH-1:0] top = '0;
    logic [PC_WIDTH-1:0] pc;
    int err_total = 0;
    int compares = 0;
    int cycles = 0;

    return_path_exec dut (.CLK_IN(clk), .SYS_RST_IN(rst), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
        .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(4'hF), .WB_DAT_IN(wdat),
        .WB_DAT_OUT(dat_out), .WB_ACK_OUT(ack), .EXEC_VALID_IN(xvalid), .EXEC_IN(xin),
        .STACK_TOP_IN(top), .EXEC_READY_OUT(ready), .STACK_POP_OUT(pop),
        .PC_LOAD_OUT(load), .PC_OUT(pc), .FETCH_NOP_OUT(nop));

    initial begin
        forever #5 clk = ~clk;
    end

    // hang guard, far above the hundred-odd cycles the run needs
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            chk(32'h0, 32'h1, "timeout");
            end_sim();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk

    // classic cycle: hold everything until ack is sampled high, then release
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        rdat = dat_out;
        chk(32'(n < 50), 32'h1, "no ack");
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wb

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(rdat, exp, "read");
    endtask : rd

    // offer one return; the take edge is where ready is sampled high
    task automatic ret(input ret_op_t op, input logic f, input logic [7:0] lit,
                       input logic [PC_WIDTH-1:0] t);
        int n;
        n = 0;
        @(posedge clk);
        xvalid <= 1'b1;
        xin <= '{op, f, lit};
        top <= t;
        do begin
            @(posedge clk);
            n++;
        end while (ready !== 1'b1 && n < 50);
        xvalid <= 1'b0;
        #1;
        chk(32'({pop, load, nop, ready}), 32'hE, "first cycle");
        chk(32'(pc), 32'(t), "pc");
        @(posedge clk);
        #1;
        chk(32'({pop, load, nop, ready}), 32'h1, "after nop");
    endtask : ret

    task automatic t_reset;
        rd(OFF_ACC, 32'h0);
        rd(OFF_IRQ, 32'h0);
        rd(OFF_PC, 32'h0);
        rd(OFF_STATUS, 32'h1);
        rd(8'h40, 32'h0);
    endtask : t_reset

    task automatic t_fast;
        wb(1'b1, OFF_ACC, 32'h11);
        wb(1'b1, OFF_FLAGS, 32'h22);
        wb(1'b1, OFF_BANK, 32'h03);
        wb(1'b1, OFF_ACC_SH, 32'hAA);
        wb(1'b1, OFF_FLAGS_SH, 32'h55);
        wb(1'b1, OFF_BANK_SH, 32'h0C);
        wb(1'b1, OFF_LATCH, 32'h1A5C);
        ret(OP_IRQ_RETURN, 1'b1, 8'h00, 21'h1ABCDE);
        rd(OFF_ACC, 32'hAA);
        rd(OFF_FLAGS, 32'h55);
        rd(OFF_BANK, 32'h0C);
        rd(OFF_IRQ, 32'h1);
        rd(OFF_PC, 32'h1ABCDE);
        rd(OFF_LATCH, 32'h1A5C);
    endtask : t_fast

    task automatic t_plain;
        wb(1'b1, OFF_ACC, 32'h33);
        ret(OP_SUB_RETURN, 1'b0, 8'h00, 21'h000102);
        rd(OFF_ACC, 32'h33);
        rd(OFF_FLAGS, 32'h55);
        rd(OFF_BANK, 32'h0C);
        ret(OP_IRQ_RETURN, 1'b0, 8'h00, 21'h0F0F0F);
        rd(OFF_ACC, 32'h33);
        ret(OP_SUB_RETURN, 1'b1, 8'h00, 21'h000204);
        rd(OFF_ACC, 32'hAA);
        rd(OFF_PC, 32'h000204);
    endtask : t_plain

    task automatic t_literal;
        ret(OP_LITERAL_RETURN, 1'b1, 8'hC7, 21'h1FFFFE);
        rd(OFF_ACC, 32'hC7);
        rd(OFF_FLAGS, 32'h55);
        rd(OFF_LATCH, 32'h1A5C);
    endtask : t_literal

    // priority mode: low enable gets set when the high one is already set, else the high one
    task automatic t_prio;
        wb(1'b1, OFF_IRQ, 32'h5);
        ret(OP_IRQ_RETURN, 1'b0, 8'h00, 21'h000010);
        rd(OFF_IRQ, 32'h7);
        wb(1'b1, OFF_IRQ, 32'h4);
        ret(OP_IRQ_RETURN, 1'b0, 8'h00, 21'h000020);
        rd(OFF_IRQ, 32'h5);
    endtask : t_prio

    task automatic end_sim;
        if (err_total == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_sim

    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_fast();
        t_plain();
        t_literal();
        t_prio();
        end_sim();
    end
endmodule : return_path_exec_tb_top
`default_nettype wire
